// ### common/hp_params.svh
// Addresses, field positions and timing counts for the host port block
`ifndef HP_PARAMS_SVH
`define HP_PARAMS_SVH
`define HP_ADDR_PLL 8'h00
`define HP_ADDR_STATUS 8'h01
`define HP_ADDR_MISC 8'h02
`define HP_ADDR_COEF_START 8'h03
`define HP_ADDR_COEF_STOP 8'h04
`define HP_ADDR_COEF_DATA 8'h05
`define HP_ADDR_CH_BASE 8'h68
`define HP_ADDR_OUT_ENA 8'h68
`define HP_ADDR_OUT_FMT 8'h69
`define HP_ADDR_CH_LAST 8'he7
`define HP_ADDR_RES_IQ 8'ha0
`define HP_ADDR_RES_RSSI 8'hac
`define HP_BIT_BYTE_MODE 0
`define HP_BIT_FIR_ENA 1
`define HP_SETTLE_US 200
`define HP_CLK_MHZ 10
`define HP_SETTLE_CYC (`HP_SETTLE_US * `HP_CLK_MHZ)
`define HP_ACC_EDGES 2'h2
`define HP_RST16 16'h0000
`endif

// ### common/hp_pkg.sv
// Types shared by the host port block
package hp_pkg;
    typedef enum logic [1:0] {
        HP_IDLE = 2'b00,
        HP_BUSY = 2'b01,
        HP_DONE = 2'b10,
        HP_HANG = 2'b11
    } hp_acc_t;
    typedef enum logic [1:0] {
        HP_FMT_IQG = 2'b00,
        HP_FMT_PARG = 2'b01,
        HP_FMT_IQ = 2'b10,
        HP_FMT_PAR = 2'b11
    } hp_fmt_t;
    typedef enum logic [1:0] {
        HP_SEQ_IDLE = 2'b00,
        HP_SEQ_WORD = 2'b01,
        HP_SEQ_OVH = 2'b10
    } hp_seq_t;
endpackage

// ### design/hp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
module hp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // Storage words
    logic [AW-1:0] wptr;  // Write pointer
    logic [AW-1:0] rptr;  // Read pointer
    logic [AW:0] count;  // Fill level
    logic push;
    logic pop;

    // Honest flags straight from the fill level
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
            end
            if (pop) begin
                rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ### design/hp_host_port.sv
// Host microport, result readback and parallel output sequencer
// Summary of operation
// - Per channel read-only latest in-phase sample
// - Per channel read-only latest quadrature sample
// - Strength register updates only while loop runs
// - Style A: ready low during access, high after
// - Style B: acknowledge driven low on completion
// - Unmapped address never completes; bus hangs
// - Held chip select starts another access
// - Byte mode ignores upper data byte
// - Disabled filters: coefficient reads not stored data
// - PLL off by default; settle before channel writes
// - One overhead clock per output cycle
// - Per channel clocks: 3, 2, 2 or 1
// - A channel's words stay on one port
// - Samples pass as two's complement
// - Scan reset low: pins functionally driven
`include "hp_params.svh"
module hp_host_port #(
    parameter int NCH = 6,
    parameter int FIFO_DEPTH = 4,
    parameter int COEF_WORDS = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_port_clock,
    input wire logic chip_select_n,
    input wire logic data_strobe_n,
    input wire logic rw_wr_n,
    input wire logic [7:0] addr,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic transfer_ack_out,
    output logic transfer_ack_oe,
    input wire logic bus_style_b,
    input wire logic scan_reset_n,
    output logic scan_owns_pins,
    input wire logic [NCH*16-1:0] ch_i,
    input wire logic [NCH*16-1:0] ch_q,
    input wire logic [NCH-1:0] ch_iq_valid,
    input wire logic [NCH*12-1:0] ch_strength,
    input wire logic [NCH-1:0] ch_strength_valid,
    input wire logic [NCH-1:0] ch_loop_run,
    input wire logic frame_start,
    output logic [15:0] port_data,
    output logic port_valid,
    input wire logic port_ready,
    output logic pll_settled
);
    localparam int CW = $clog2(COEF_WORDS);
    localparam logic [11:0] SETTLE_CYC = 12'(`HP_SETTLE_CYC);

    // Two-stage synchronisers for every pin input
    logic [29:0] sync1;  // First stage, read only by sync2
    logic [29:0] sync2;  // Second stage, safe to use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= '1;
            sync2 <= '1;
        end else begin
            sync1 <= {host_port_clock, chip_select_n, data_strobe_n, rw_wr_n,
                      addr, data_in, bus_style_b, scan_reset_n};
            sync2 <= sync1;
        end
    end
    logic hclk_s;
    logic cs_n_s;
    logic ds_n_s;
    logic rw_n_s;
    logic [7:0] addr_s;
    logic [15:0] din_s;
    logic style_b_s;
    logic scan_rst_n_s;
    assign {hclk_s, cs_n_s, ds_n_s, rw_n_s, addr_s, din_s, style_b_s,
            scan_rst_n_s} = sync2;

    // Host clock edge finder on the synchronised copy
    logic hclk_d;
    logic hedge;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Matches the synchroniser's reset level, so no false edge
            hclk_d <= 1'b1;
        end else begin
            hclk_d <= hclk_s;
        end
    end
    assign hedge = hclk_s && !hclk_d;

    // Access request decode; style A has separate read and write strobes
    logic req;
    logic is_wr;
    assign req = !cs_n_s && (!ds_n_s || (!style_b_s && !rw_n_s));
    assign is_wr = !rw_n_s;

    // Programmable state
    logic [15:0] pll_cfg;  // Multiplier/divider, zero means off
    logic [15:0] misc;  // Byte mode and filter enable
    logic [CW-1:0] coef_start;
    logic [CW-1:0] coef_stop;
    logic [CW-1:0] coef_ptr;  // Current coefficient RAM address
    logic [15:0] coef_ram [COEF_WORDS];
    logic [15:0] out_ena;  // Channel enables for the output port
    logic [15:0] out_fmt;  // Two format bits per channel
    logic [11:0] settle_cnt;

    // Result registers
    logic [15:0] res_i [NCH];
    logic [15:0] res_q [NCH];
    logic [11:0] res_rssi [NCH];

    // Capture of per-channel results, one slice per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_res
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    res_i[g] <= `HP_RST16;
                    res_q[g] <= `HP_RST16;
                    res_rssi[g] <= '0;
                end else begin
                    // Datapath samples land even with the loop bypassed
                    if (ch_iq_valid[g]) begin
                        res_i[g] <= ch_i[g*16 +: 16];
                        res_q[g] <= ch_q[g*16 +: 16];
                    end
                    // Strength holds unless the loop is running
                    if (ch_strength_valid[g] && ch_loop_run[g]) begin
                        res_rssi[g] <= ch_strength[g*12 +: 12];
                    end
                end
            end
        end
    endgenerate

    // Address map check; anything else is left hanging
    logic mapped;
    logic is_res;
    always_comb begin
        mapped = 1'b0;
        is_res = 1'b0;
        case (addr_s)
            `HP_ADDR_PLL, `HP_ADDR_STATUS, `HP_ADDR_MISC, `HP_ADDR_COEF_START,
            `HP_ADDR_COEF_STOP, `HP_ADDR_COEF_DATA, `HP_ADDR_OUT_ENA,
            `HP_ADDR_OUT_FMT: begin
                mapped = 1'b1;
            end
            default: begin
                if (addr_s >= `HP_ADDR_RES_IQ
                    && addr_s < `HP_ADDR_RES_RSSI + 8'(NCH)) begin
                    mapped = 1'b1;
                    is_res = 1'b1;
                end
            end
        endcase
    end

    // Read mux
    logic [15:0] rd_val;
    logic [7:0] roff;
    assign roff = addr_s - `HP_ADDR_RES_IQ;
    always_comb begin
        rd_val = '0;
        case (addr_s)
            `HP_ADDR_PLL: rd_val = pll_cfg;
            `HP_ADDR_STATUS: rd_val = {15'h0000, pll_settled};
            `HP_ADDR_MISC: rd_val = misc;
            `HP_ADDR_COEF_START: rd_val = 16'(coef_start);
            `HP_ADDR_COEF_STOP: rd_val = 16'(coef_stop);
            // Stopped RAM clock means nothing stored comes back
            `HP_ADDR_COEF_DATA: rd_val = misc[`HP_BIT_FIR_ENA] ?
                coef_ram[coef_ptr] : '0;
            `HP_ADDR_OUT_ENA: rd_val = out_ena;
            `HP_ADDR_OUT_FMT: rd_val = out_fmt;
            default: begin
                if (addr_s >= `HP_ADDR_RES_RSSI) begin
                    rd_val = {4'h0, res_rssi[3'(addr_s - `HP_ADDR_RES_RSSI)]};
                end else if (is_res) begin
                    rd_val = roff[0] ? res_q[3'(roff[7:1])] : res_i[3'(roff[7:1])];
                end
            end
        endcase
    end

    // Access state machine, paced by host clock edges
    hp_pkg::hp_acc_t acc;
    logic [1:0] acc_cnt;
    logic wr_fire;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc <= hp_pkg::HP_IDLE;
            acc_cnt <= '0;
        end else begin
            case (acc)
                hp_pkg::HP_IDLE: begin
                    if (hedge && req) begin
                        acc <= mapped ? hp_pkg::HP_BUSY : hp_pkg::HP_HANG;
                        acc_cnt <= '0;
                    end
                end
                hp_pkg::HP_BUSY: begin
                    // Select released early abandons the access
                    if (cs_n_s) begin
                        acc <= hp_pkg::HP_IDLE;
                    end else if (hedge) begin
                        acc_cnt <= acc_cnt + 1'b1;
                        if (acc_cnt == `HP_ACC_EDGES - 2'h1) begin
                            acc <= hp_pkg::HP_DONE;
                        end
                    end
                end
                hp_pkg::HP_DONE: begin
                    if (cs_n_s) begin
                        acc <= hp_pkg::HP_IDLE;
                    end else if (hedge) begin
                        // Select still low: a fresh access begins
                        acc <= hp_pkg::HP_BUSY;
                        acc_cnt <= '0;
                    end
                end
                hp_pkg::HP_HANG: begin
                    // No acknowledge ever; only releasing select frees it
                    if (cs_n_s) begin
                        acc <= hp_pkg::HP_IDLE;
                    end
                end
                default: acc <= hp_pkg::HP_IDLE;
            endcase
        end
    end
    assign wr_fire = (acc == hp_pkg::HP_BUSY) && !cs_n_s && hedge
        && (acc_cnt == `HP_ACC_EDGES - 2'h1);

    // Write data; byte mode drops the upper lane
    logic [15:0] wdata;
    logic ch_locked;
    assign wdata = misc[`HP_BIT_BYTE_MODE] ? {8'h00, din_s[7:0]} : din_s;
    assign ch_locked = !pll_settled && addr_s >= `HP_ADDR_CH_BASE
        && addr_s <= `HP_ADDR_CH_LAST;

    // Register writes; result addresses complete but store nothing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pll_cfg <= `HP_RST16;
            misc <= `HP_RST16;
            coef_start <= '0;
            coef_stop <= '0;
            out_ena <= `HP_RST16;
            out_fmt <= `HP_RST16;
        end else if (wr_fire && is_wr && !ch_locked) begin
            case (addr_s)
                `HP_ADDR_PLL: pll_cfg <= wdata;
                `HP_ADDR_MISC: misc <= wdata;
                `HP_ADDR_COEF_START: coef_start <= wdata[CW-1:0];
                `HP_ADDR_COEF_STOP: coef_stop <= wdata[CW-1:0];
                `HP_ADDR_OUT_ENA: out_ena <= wdata;
                `HP_ADDR_OUT_FMT: out_fmt <= wdata;
                default: ;
            endcase
        end
    end

    // Coefficient RAM, pointer steps on every completed data access
    always_ff @(posedge clk) begin
        if (wr_fire && is_wr && addr_s == `HP_ADDR_COEF_DATA
            && misc[`HP_BIT_FIR_ENA]) begin
            coef_ram[coef_ptr] <= wdata;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coef_ptr <= '0;
        end else if (wr_fire && addr_s == `HP_ADDR_COEF_START && is_wr) begin
            coef_ptr <= wdata[CW-1:0];
        end else if (wr_fire && addr_s == `HP_ADDR_COEF_DATA) begin
            // Repeat accesses land on the next address
            coef_ptr <= (coef_ptr == coef_stop) ? coef_start : coef_ptr + 1'b1;
        end
    end

    // PLL settle timer, starts once a nonzero setting is written
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_cnt <= '0;
            pll_settled <= 1'b0;
        end else if (pll_cfg == `HP_RST16) begin
            settle_cnt <= '0;
            pll_settled <= 1'b0;
        end else if (settle_cnt == SETTLE_CYC - 12'h001) begin
            pll_settled <= 1'b1;
        end else begin
            settle_cnt <= settle_cnt + 12'h001;
        end
    end

    // Read data held from completion until the next access completes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_out <= '0;
        end else if (wr_fire) begin
            data_out <= rd_val;
        end
    end

    // Pin drive: scan logic owns the pins only when its reset is high
    logic func;
    assign func = !scan_rst_n_s;
    assign scan_owns_pins = scan_rst_n_s;
    assign data_oe = func && acc == hp_pkg::HP_DONE && !is_wr && !style_b_s
        ? 1'b1 : func && acc == hp_pkg::HP_DONE && !is_wr && rw_n_s;
    assign transfer_ack_out = 1'b0;
    // Style A pulls low while busy; style B pulls low once done
    assign transfer_ack_oe = func && (style_b_s ? acc == hp_pkg::HP_DONE
        : (acc == hp_pkg::HP_BUSY || acc == hp_pkg::HP_HANG));

    // Output sequencer: words per channel from its format, then overhead
    hp_pkg::hp_seq_t seq;
    logic [NCH-1:0] pend;  // Channels still to send this cycle
    logic [2:0] cur;  // Lowest pending channel
    logic [1:0] widx;
    logic [1:0] nwords;
    hp_pkg::hp_fmt_t fmt;
    logic [15:0] word;
    logic f_ready;
    logic f_push;
    always_comb begin
        cur = '0;
        for (int k = NCH - 1; k >= 0; k--) begin
            if (pend[k]) begin
                cur = 3'(k);
            end
        end
    end
    assign fmt = hp_pkg::hp_fmt_t'(out_fmt[cur*2 +: 2]);
    // Word count per channel and the word in each slot
    always_comb begin
        nwords = 2'h2;
        word = res_i[cur];
        case (fmt)
            hp_pkg::HP_FMT_IQG: begin
                nwords = 2'h3;
                word = widx == 2'h0 ? res_i[cur] : widx == 2'h1 ? res_q[cur]
                    : {4'h0, res_rssi[cur]};
            end
            hp_pkg::HP_FMT_PARG: begin
                word = widx == 2'h0 ? {res_i[cur][15:8], res_q[cur][15:8]}
                    : {4'h0, res_rssi[cur]};
            end
            hp_pkg::HP_FMT_IQ: begin
                word = widx == 2'h0 ? res_i[cur] : res_q[cur];
            end
            hp_pkg::HP_FMT_PAR: begin
                nwords = 2'h1;
                word = {res_i[cur][15:8], res_q[cur][15:8]};
            end
            default: ;
        endcase
    end
    assign f_push = (seq == hp_pkg::HP_SEQ_WORD);
    // Sequencer stalls while the FIFO is full
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq <= hp_pkg::HP_SEQ_IDLE;
            pend <= '0;
            widx <= '0;
        end else begin
            case (seq)
                hp_pkg::HP_SEQ_IDLE: begin
                    if (frame_start && out_ena[NCH-1:0] != '0) begin
                        pend <= out_ena[NCH-1:0];
                        widx <= '0;
                        seq <= hp_pkg::HP_SEQ_WORD;
                    end
                end
                hp_pkg::HP_SEQ_WORD: begin
                    if (f_ready) begin
                        if (widx == nwords - 2'h1) begin
                            // All of one channel's words before the next
                            widx <= '0;
                            pend[cur] <= 1'b0;
                            if ((pend & ~(NCH'(1) << cur)) == '0) begin
                                seq <= hp_pkg::HP_SEQ_OVH;
                            end
                        end else begin
                            widx <= widx + 2'h1;
                        end
                    end
                end
                hp_pkg::HP_SEQ_OVH: begin
                    seq <= hp_pkg::HP_SEQ_IDLE;
                end
                default: seq <= hp_pkg::HP_SEQ_IDLE;
            endcase
        end
    end

    // Output buffer toward the parallel port
    hp_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(f_push),
        .in_ready(f_ready),
        .in_data(word),
        .out_valid(port_valid),
        .out_ready(port_ready),
        .out_data(port_data)
    );
endmodule

// ### verif/hp_host_port_properties.sv
// Concurrent checks on the host port block's pins
module hp_host_port_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic bus_style_b,
    input wire logic transfer_ack_out,
    input wire logic transfer_ack_oe,
    input wire logic data_oe,
    input wire logic scan_owns_pins,
    input wire logic [15:0] port_data,
    input wire logic port_valid,
    input wire logic port_ready,
    input wire logic pll_settled
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Cycles since reset; saturates so it never wraps under the settle figure
    logic [11:0] up_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            up_cnt <= 12'h000;
        end else if (up_cnt != 12'hfff) begin
            up_cnt <= up_cnt + 12'h001;
        end
    end
    // Select seen released long enough to pass the synchronisers
    sequence cs_idle;
        chip_select_n [*6];
    endsequence
    // Style A access begins: ready pulled low
    sequence ready_falls;
        $rose(transfer_ack_oe) && !bus_style_b;
    endsequence
    chk_ack_open_drain: assert property (transfer_ack_out == 1'b0)
        else $error("acknowledge pin driven high");
    chk_scan_pins_free: assert property (scan_owns_pins |-> !data_oe && !transfer_ack_oe)
        else $error("pin driven while scan owns pins");
    chk_ready_low_time: assert property (ready_falls |-> transfer_ack_oe [*8])
        else $error("ready returned high too soon");
    chk_ack_has_cause: assert property ($rose(transfer_ack_oe) |-> $past(chip_select_n, 3) == 1'b0)
        else $error("handshake pin moved without select");
    chk_ack_b_stands: assert property (bus_style_b && transfer_ack_oe && !chip_select_n
        && !scan_owns_pins |=> transfer_ack_oe)
        else $error("acknowledge dropped while selected");
    chk_idle_release: assert property (cs_idle |-> !transfer_ack_oe && !data_oe)
        else $error("pins still driven after release");
    chk_read_drive: assert property (data_oe |-> bus_style_b == transfer_ack_oe)
        else $error("read data without completion");
    chk_pll_wait: assert property (pll_settled |-> up_cnt >= 12'h7d0)
        else $error("settled flag too early");
    chk_port_holds: assert property (port_valid && !port_ready
        |=> port_valid && $stable(port_data))
        else $error("output word lost before taken");
endmodule
bind hp_host_port hp_host_port_properties u_props (.clk(clk), .rst(rst),
    .chip_select_n(chip_select_n), .bus_style_b(bus_style_b),
    .transfer_ack_out(transfer_ack_out), .transfer_ack_oe(transfer_ack_oe),
    .data_oe(data_oe), .scan_owns_pins(scan_owns_pins), .port_data(port_data),
    .port_valid(port_valid), .port_ready(port_ready), .pll_settled(pll_settled));

// ### verif/hp_host_model.sv
// Host-side partner: gated host port clock and pulled-up acknowledge pin
module hp_host_model (
    input wire logic run,
    input wire logic transfer_ack_oe,
    output logic host_port_clock,
    output logic ack_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // External pull-up: pin high unless the device pulls it low
    assign ack_pin = transfer_ack_oe ? 1'b0 : 1'b1;
    // 800 ns clock, slower than clk; stops low between accesses
    initial begin
        host_port_clock = 1'b0;
        #37;
        forever begin
            #400;
            if (run || host_port_clock) begin
                host_port_clock = ~host_port_clock;
            end
        end
    end
endmodule

// ### verif/tb.sv
// Self-checking bench for the host port block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, cs_n, ds_n, rw_n, style_b, scan_n, run, fs, p_ready, ok;
    logic data_oe, ack_oe, scan_owns, port_valid, pll_settled, hclk, ack_pin;
    logic [7:0] addr;
    logic [15:0] host_d, q, data_out, port_data;
    logic [95:0] ch_i, ch_q;
    logic [71:0] ch_s;
    logic [5:0] iq_v, s_v, loop_run;
    logic [15:0] exp_q[$];
    wire [15:0] bus_d;
    int mismatches, checks, cyc, i, n_st;
    // Shared data wire: device drives it only for read data
    assign bus_d = data_oe ? data_out : host_d;
    hp_host_model u_host (.run(run), .transfer_ack_oe(ack_oe), .host_port_clock(hclk),
        .ack_pin(ack_pin));
    hp_host_port DUT (.clk(clk), .rst(rst), .host_port_clock(hclk), .chip_select_n(cs_n),
        .data_strobe_n(ds_n), .rw_wr_n(rw_n), .addr(addr), .data_in(bus_d),
        .data_out(data_out), .data_oe(data_oe), .transfer_ack_out(), .transfer_ack_oe(ack_oe),
        .bus_style_b(style_b), .scan_reset_n(scan_n), .scan_owns_pins(scan_owns),
        .ch_i(ch_i), .ch_q(ch_q), .ch_iq_valid(iq_v), .ch_strength(ch_s),
        .ch_strength_valid(s_v), .ch_loop_run(loop_run), .frame_start(fs),
        .port_data(port_data), .port_valid(port_valid), .port_ready(p_ready),
        .pll_settled(pll_settled));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches = mismatches + 1;
            end_sim();
        end
    end
    task end_sim;
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One bus access; strobes held until completion, ok low if it never ends
    task acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
        int n;
        logic seen;
        seen = 1'b0;
        ok = 1'b0;
        @(posedge clk);
        cs_n <= 1'b0;
        rw_n <= !wr;
        ds_n <= style_b ? 1'b0 : wr;
        addr <= a;
        host_d <= d;
        run <= 1'b1;
        for (n = 0; n < 80 && !ok; n++) begin
            @(posedge clk);
            if (style_b) ok = !ack_pin;
            else begin
                ok = seen && ack_pin;
                seen = seen || !ack_pin;
            end
        end
        q = bus_d;
        cs_n <= 1'b1;
        ds_n <= 1'b1;
        rw_n <= 1'b1;
        host_d <= ~d;
        run <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // Words expected for one channel in one format
    task push_exp(input int c, input int f);
        logic [15:0] iv, qv, rv;
        iv = 16'h8001 + 16'(c);
        qv = 16'h7ff0 - 16'(c);
        rv = c[0] ? 16'h0000 : 16'h0800 + 16'(c);
        if (f[0]) exp_q.push_back({iv[15:8], qv[15:8]});
        else begin
            exp_q.push_back(iv);
            exp_q.push_back(qv);
        end
        if (!f[1]) exp_q.push_back(rv);
    endtask
    // Start an output cycle, stall the reader 20 cycles so the FIFO fills when it has more than 4 words, then drain
    task frame;
        int n;
        @(posedge clk);
        fs <= 1'b1;
        @(posedge clk);
        fs <= 1'b0;
        repeat (20) @(posedge clk);
        p_ready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (port_valid === 1'b1) chk(port_data, exp_q.size() ? exp_q.pop_front() : 16'hdead);
        end
        p_ready <= 1'b0;
        chk(16'(exp_q.size()), 16'h0000);
    endtask
    initial begin
        {rst, cs_n, ds_n, rw_n} = 4'hf;
        {style_b, scan_n, run, fs, p_ready} = 5'h00;
        addr = 8'h00;
        host_d = 16'h0000;
        {iq_v, s_v, loop_run} = 18'h00000;
        {mismatches, checks, cyc} = {32'd0, 32'd0, 32'd0};
        for (i = 0; i < 6; i++) begin
            ch_i[i*16+:16] = 16'h8001 + 16'(i);
            ch_q[i*16+:16] = 16'h7ff0 - 16'(i);
            ch_s[i*12+:12] = 12'h800 + 12'(i);
        end
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        iq_v <= 6'h3f;
        s_v <= 6'h3f;
        loop_run <= 6'h15;
        @(posedge clk);
        loop_run <= 6'h00;
        ch_s <= {6{12'h123}};
        @(posedge clk);
        {iq_v, s_v} <= 12'h000;
        chk({15'h0, pll_settled}, 16'h0000);
        for (i = 0; i < 6; i++) begin
            acc(1'b0, 8'ha0 + 8'(2 * i), 16'h0000);
            chk(q, 16'h8001 + 16'(i));
            acc(1'b0, 8'ha1 + 8'(2 * i), 16'h0000);
            chk(q, 16'h7ff0 - 16'(i));
            acc(1'b0, 8'hac + 8'(i), 16'h0000);
            chk(q, i[0] ? 16'h0000 : 16'h0800 + 16'(i));
        end
        style_b <= 1'b1;
        acc(1'b1, 8'ha0, 16'h5a5a);
        chk({15'h0, ok}, 16'h0001);
        acc(1'b0, 8'ha0, 16'h0000);
        chk(q, 16'h8001);
        acc(1'b0, 8'he8, 16'h0000);
        chk({15'h0, ok}, 16'h0000);
        style_b <= 1'b0;
        acc(1'b1, 8'hff, 16'h0000);
        chk({15'h0, ok}, 16'h0000);
        acc(1'b1, 8'h02, 16'h0001);
        acc(1'b1, 8'h03, 16'hab03);
        acc(1'b1, 8'h04, 16'h0003);
        acc(1'b0, 8'h03, 16'h0000);
        chk(q, 16'h0003);
        acc(1'b1, 8'h05, 16'h1234);
        acc(1'b0, 8'h05, 16'h0000);
        chk(q, 16'h0000);
        acc(1'b1, 8'h02, 16'h0002);
        acc(1'b1, 8'h05, 16'h1234);
        acc(1'b0, 8'h05, 16'h0000);
        chk(q, 16'h1234);
        // Select held past completion: the port starts over by itself
        ok = 1'b1;
        n_st = 0;
        @(posedge clk);
        cs_n <= 1'b0;
        ds_n <= 1'b0;
        addr <= 8'h05;
        run <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge clk);
            if (!ack_pin && ok) n_st = n_st + 1;
            ok = ack_pin;
        end
        cs_n <= 1'b1;
        ds_n <= 1'b1;
        run <= 1'b0;
        repeat (8) @(posedge clk);
        chk({15'h0, n_st > 1}, 16'h0001);
        acc(1'b1, 8'h68, 16'h0003);
        acc(1'b0, 8'h68, 16'h0000);
        chk(q, 16'h0000);
        acc(1'b1, 8'h00, 16'h0001);
        for (i = 0; i < 2100 && pll_settled !== 1'b1; i++) @(posedge clk);
        acc(1'b0, 8'h01, 16'h0000);
        chk(q, 16'h0001);
        // Unlocked now, so only read-only protection keeps the value
        acc(1'b1, 8'ha2, 16'h5a5a);
        acc(1'b0, 8'ha2, 16'h0000);
        chk(q, 16'h8002);
        acc(1'b1, 8'h69, 16'h0000);
        acc(1'b1, 8'h68, 16'h0003);
        push_exp(0, 0);
        push_exp(1, 0);
        frame();
        acc(1'b1, 8'h68, 16'h0001);
        for (i = 1; i < 4; i++) begin
            acc(1'b1, 8'h69, 16'(i));
            push_exp(0, i);
            frame();
        end
        scan_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({15'h0, scan_owns}, 16'h0001);
        scan_n <= 1'b0;
        end_sim();
    end
endmodule
